//--- core/adcsr_readout.sv
// Serial conversion start and result readout of a 12-bit sampling converter
//
// Function
// - All four clock polarity/phase modes work unconfigured.
// - Convert-start fall begins conversion, output driven low.
// - Data output changes only on rising clock edges.
// - Readout takes sixteen host clocks, twelve result bits.
// - Frame: three zeros, result MSB first, one zero.
// - A raise on edges four to fourteen enters partial, then full power-down.
// - Fourteen clocks with convert-start low wakes converter.
// - MSB appears on fourth rising edge after start.
`timescale 1ns/1ps
`include "adcsr_defs.svh"

module adcsr_readout
  import adcsr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire adcsr_word_s sample_i,
  input  wire logic        sample_valid_i,
  output logic             sample_ready_o,
  output logic             conv_start_o,
  output adcsr_mode_e      power_mode_o,
  input  wire logic        sclk_i,
  input  wire logic        convert_start_n_i,
  output logic             dout_o,
  output logic             dout_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // System domain: result hand-off, start event and mode status
  adcsr_word_s xfer_q,      xfer_d;
  logic        busy_q,      busy_d;
  logic        req_q,       req_d;
  logic        ack_s1_q,    ack_s2_q;
  logic        cv_s1_q,     cv_s2_q,   cv_s3_q;
  adcsr_mode_e md_s1_q,     md_s2_q,   md_s3_q;
  adcsr_mode_e mode_out_q,  mode_out_d;
  logic        pulse_q,     pulse_d;

  // Word stays frozen until the link side acknowledges, so it is safe to read there
  always_comb begin
    xfer_d     = xfer_q;
    busy_d     = busy_q;
    req_d      = req_q;
    mode_out_d = mode_out_q;
    pulse_d    = cv_s2_q != cv_s3_q;
    if (busy_q && (ack_s2_q == req_q)) begin
      busy_d = 1'b0;
    end
    if (!busy_q && sample_valid_i) begin
      xfer_d = sample_i;
      req_d  = ~req_q;
      busy_d = 1'b1;
    end
    // Two equal samples filter the two-bit skew of a mode change
    if (md_s2_q == md_s3_q) begin
      mode_out_d = md_s3_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      xfer_q     <= '0;
      busy_q     <= 1'b0;
      req_q      <= 1'b0;
      mode_out_q <= ADCSR_NORMAL;
      pulse_q    <= 1'b0;
    end else begin
      xfer_q     <= xfer_d;
      busy_q     <= busy_d;
      req_q      <= req_d;
      mode_out_q <= mode_out_d;
      pulse_q    <= pulse_d;
    end
  end

  logic        lk_ack_q;
  logic        conv_tgl_q;
  adcsr_mode_e mode_q;

  always_ff @(posedge clock_i) begin
    ack_s1_q <= lk_ack_q;
    ack_s2_q <= ack_s1_q;
    cv_s1_q  <= conv_tgl_q;
    cv_s2_q  <= cv_s1_q;
    cv_s3_q  <= cv_s2_q;
    md_s1_q  <= mode_q;
    md_s2_q  <= md_s1_q;
    md_s3_q  <= md_s2_q;
  end

  assign sample_ready_o = !busy_q;
  assign conv_start_o   = pulse_q;
  assign power_mode_o   = mode_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame sequencing on the host serial clock
  logic lrst_s1_q, lrst_n_q;
  logic req_s1_q,  req_s2_q, req_s3_q;

  // Reset only takes effect while the host clock runs
  always_ff @(posedge sclk_i) begin
    lrst_s1_q <= rst_n_i;
    lrst_n_q  <= lrst_s1_q;
    req_s1_q  <= req_q;
    req_s2_q  <= req_s1_q;
    req_s3_q  <= req_s2_q;
  end

  adcsr_state_e           st_q,     st_d;
  logic [`ADCSR_CNT_W-1:0] cnt_q,    cnt_d;
  logic [15:0]            sh_q,     sh_d;
  logic                   dout_q,   dout_d;
  logic                   armed_q,  armed_d;
  logic                   cont_q,   cont_d;
  adcsr_mode_e            mode_d;
  adcsr_word_s            word_q,   word_d;
  adcsr_word_s            fword_q,  fword_d;
  logic                   conv_tgl_d;
  logic                   lk_ack_d;
  logic [`ADCSR_CNT_W-1:0] cnt_nx;
  logic                   cs_n;
  logic                   drive;

  assign cs_n   = convert_start_n_i;
  assign cnt_nx = cnt_q + `ADCSR_CNT_W'(1);

  // Convert-start is launched by the host off the same serial clock, so it is sampled
  // directly: two synchroniser stages would shift every edge count by two.
  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    dout_d     = dout_q;
    armed_d    = armed_q;
    cont_d     = cont_q;
    mode_d     = mode_q;
    word_d     = word_q;
    fword_d    = fword_q;
    conv_tgl_d = conv_tgl_q;
    lk_ack_d   = req_s3_q;
    if (req_s2_q != req_s3_q) begin
      word_d = xfer_q;
    end
    unique case (st_q)
      ADCSR_IDLE: begin
        dout_d  = 1'b0;
        armed_d = armed_q | cs_n;
      end
      ADCSR_ACTIVE: begin
        cnt_d  = cnt_nx;
        dout_d = sh_q[15];
        sh_d   = {sh_q[14:0], 1'b0};
        if (!cs_n && cnt_nx == `ADCSR_CNT_W'(`ADCSR_WAKE_EDGE)) begin
          mode_d = ADCSR_NORMAL;
        end
        if (cs_n && cnt_nx <= `ADCSR_CNT_W'(`ADCSR_LEAD_ZEROS)) begin
          st_d    = ADCSR_IDLE;
          dout_d  = 1'b0;
          armed_d = 1'b1;
        end else if (cs_n && cnt_nx <= `ADCSR_CNT_W'(`ADCSR_PD_LAST)) begin
          st_d    = ADCSR_IDLE;
          dout_d  = 1'b0;
          armed_d = 1'b1;
          mode_d  = (mode_q == ADCSR_NORMAL) ? ADCSR_PARTIAL : ADCSR_FULL;
        end else begin
          if (cs_n) begin
            cont_d = 1'b1;
          end
          if (cnt_nx == `ADCSR_CNT_W'(`ADCSR_FRAME_LEN)) begin
            st_d = (cont_q || cs_n) ? ADCSR_CONT : ADCSR_TAIL;
          end
        end
      end
      ADCSR_TAIL: begin
        dout_d  = 1'b0;
        st_d    = ADCSR_IDLE;
        armed_d = cs_n;
      end
      ADCSR_CONT: begin
        dout_d  = 1'b0;
        if (cs_n) begin
          st_d    = ADCSR_IDLE;
          armed_d = 1'b1;
        end
      end
    endcase
    // A low convert-start after a high one opens a new frame; this edge is edge one
    if (!cs_n && ((st_q == ADCSR_IDLE && armed_q) || st_q == ADCSR_CONT)) begin
      st_d       = ADCSR_ACTIVE;
      cnt_d      = `ADCSR_CNT_W'(1);
      armed_d    = 1'b0;
      cont_d     = 1'b0;
      fword_d    = word_d;
      dout_d     = 1'b0;
      sh_d       = {2'b00, word_d.code, 2'b00};
      conv_tgl_d = ~conv_tgl_q;
    end
  end

  // Data launches only here, so every clock polarity/phase host sees a full bit period
  always_ff @(posedge sclk_i) begin
    if (!lrst_n_q) begin
      st_q       <= ADCSR_IDLE;
      cnt_q      <= '0;
      sh_q       <= '0;
      dout_q     <= 1'b0;
      armed_q    <= 1'b0;
      cont_q     <= 1'b0;
      mode_q     <= ADCSR_NORMAL;
      word_q     <= '0;
      fword_q    <= '0;
      conv_tgl_q <= 1'b0;
      lk_ack_q   <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      sh_q       <= sh_d;
      dout_q     <= dout_d;
      armed_q    <= armed_d;
      cont_q     <= cont_d;
      mode_q     <= mode_d;
      word_q     <= word_d;
      fword_q    <= fword_d;
      conv_tgl_q <= conv_tgl_d;
      lk_ack_q   <= lk_ack_d;
    end
  end

  // Enable drives at the convert-start fall; release follows the rise directly in TAIL and in armed IDLE, else at the rise that moves ACTIVE or CONT to IDLE
  always_comb begin
    drive = 1'b0;
    unique case (st_q)
      ADCSR_ACTIVE: drive = 1'b1;
      ADCSR_CONT:   drive = 1'b1;
      ADCSR_TAIL:   drive = !cs_n;
      ADCSR_IDLE:   drive = armed_q && !cs_n;
    endcase
  end

  assign dout_o      = dout_q;
  assign dout_oe_n_o = !drive;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the link side

  sequence s_frame_start;
    st_q == ADCSR_ACTIVE && cnt_q == `ADCSR_CNT_W'(1);
  endsequence

  sequence s_held_low3;
    (st_q == ADCSR_ACTIVE && !cs_n) [*3];
  endsequence

  a_start_drive_low: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_IDLE && armed_q && !cs_n) |-> (!dout_oe_n_o && !dout_o))
    else $error("output not driven low at conversion start");

  a_lead_zeros: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    s_frame_start ##0 s_held_low3 |-> (dout_o == 1'b0) && $past(dout_o) == 1'b0)
    else $error("leading bits not zero");

  a_msb_fourth: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    s_frame_start ##0 s_held_low3 |=> (st_q == ADCSR_ACTIVE) && (cnt_q == 5'd4) && (dout_o == fword_q.code[11]))
    else $error("MSB not presented at fourth edge");

  a_msb_first: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_ACTIVE && cnt_q >= 5'd5 && cnt_q <= 5'd15)
      |-> dout_o == fword_q.code[4'(5'd15 - cnt_q)])
    else $error("result bit out of order");

  a_trail_zero: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_ACTIVE && cnt_q == 5'd15)
      |=> (dout_o == 1'b0) && (dout_oe_n_o == (st_q == ADCSR_TAIL && cs_n)))
    else $error("trailing bit not zero");

  a_frame_sixteen: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_ACTIVE && cnt_q == 5'd15) |=> (st_q == ADCSR_TAIL || st_q == ADCSR_CONT))
    else $error("frame did not end after sixteen edges");

  a_cont_keep: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_ACTIVE && cnt_q == 5'd14 && cs_n) |-> ##2 (st_q == ADCSR_CONT && !dout_oe_n_o))
    else $error("continuous conversion not sustained");

  a_partial_pd: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_ACTIVE && mode_q == ADCSR_NORMAL && cs_n && cnt_q >= 5'd3 && cnt_q <= 5'd13)
      |=> (mode_q == ADCSR_PARTIAL && st_q == ADCSR_IDLE && dout_oe_n_o))
    else $error("partial power-down not entered");

  a_full_pd: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_ACTIVE && mode_q == ADCSR_PARTIAL && cs_n && cnt_q >= 5'd3 && cnt_q <= 5'd13)
      |=> mode_q == ADCSR_FULL)
    else $error("full power-down not entered");

  a_wake_up: assert property (@(posedge sclk_i) disable iff (!lrst_n_q)
    (st_q == ADCSR_ACTIVE && cnt_q == 5'd13 && !cs_n) |=> mode_q == ADCSR_NORMAL)
    else $error("power-down not left after fourteen clocks");

endmodule : adcsr_readout

//--- pkg/adcsr_defs.svh
// Frame positions and counts for the converter serial readout
`ifndef ADCSR_DEFS_SVH
`define ADCSR_DEFS_SVH

`define ADCSR_RES_BITS   12
`define ADCSR_FRAME_LEN  16
`define ADCSR_CNT_W      5
`define ADCSR_LEAD_ZEROS 3
`define ADCSR_MSB_EDGE   4
`define ADCSR_WAKE_EDGE  14
`define ADCSR_PD_FIRST   4
`define ADCSR_PD_LAST    14

`endif

//--- pkg/adcsr_pkg.sv
// Types shared by the converter serial readout logic
package adcsr_pkg;

  typedef enum logic [1:0] {
    ADCSR_IDLE   = 2'b00,
    ADCSR_ACTIVE = 2'b01,
    ADCSR_TAIL   = 2'b10,
    ADCSR_CONT   = 2'b11
  } adcsr_state_e;

  typedef enum logic [1:0] {
    ADCSR_NORMAL  = 2'b00,
    ADCSR_PARTIAL = 2'b01,
    ADCSR_FULL    = 2'b11
  } adcsr_mode_e;

  typedef struct packed {
    logic [11:0] code;
  } adcsr_word_s;

endpackage : adcsr_pkg

//--- verif/adcsr_host.sv
// Host serial master model: serial clock, convert start and readout capture
`timescale 1ns/1ps
module adcsr_host (
  output logic      sclk_o,
  output logic      convert_start_n_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i
);
  logic        cpol;
  logic        cpha;
  logic [31:0] rx;
  // Released pin has no pull: show a wrong level rather than the held one
  wire         line = dout_oe_n_i ? ~dout_i : dout_i;

  initial begin
    sclk_o            = 1'b0;
    convert_start_n_o = 1'b1;
    cpol              = 1'b0;
    cpha              = 1'b0;
    rx                = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 64 ns period; cs_n moves half a phase away from the rise
  task automatic cyc(input int i, input logic cs_n, input logic cap);
    if (cpol) begin
      sclk_o = 1'b0;
      if (cap && cpol != cpha && i >= 2) rx = {rx[30:0], line};
    end
    #16;
    if (cap && cpol == cpha && i >= 2) rx = {rx[30:0], line};
    convert_start_n_o = cs_n;
    #16;
    sclk_o = 1'b1;
    #32;
    if (!cpol) begin
      sclk_o = 1'b0;
      if (cap && cpol != cpha && i <= 16) rx = {rx[30:0], line};
    end
  endtask : cyc

  // Arming rises with cs_n high, then cs_n low until edge hi_at
  task automatic frame(input logic pol, input logic pha, input int hi_at);
    cpol   = pol;
    cpha   = pha;
    sclk_o = pol;
    repeat (4) cyc(0, 1'b1, 1'b0);
    for (int i = 1; i <= hi_at; i++) cyc(i, i == hi_at, 1'b1);
  endtask : frame

  // Two frames back to back; convert-start follows a transmitted word, one bit per edge
  task automatic chain(input logic pol, input logic pha);
    logic [31:0] tx;
    logic        cs;
    tx     = {16'h0001, 16'h0003};
    cpol   = pol;
    cpha   = pha;
    sclk_o = pol;
    repeat (4) cyc(0, 1'b1, 1'b0);
    // Index 1 skips the early capture, 17 the late one, 2 takes both
    for (int n = 1; n <= 33; n++) begin
      cs = (n > 32) ? 1'b1 : tx[32 - n];
      cyc((n == 1) ? 1 : ((n == 33) ? 17 : 2), cs, 1'b1);
    end
  endtask : chain
endmodule : adcsr_host

//--- verif/adcsr_readout_tb.sv
// Self-checking bench for the converter serial readout
`timescale 1ns/1ps
module adcsr_readout_tb;
  import adcsr_pkg::*;
  logic        clock_i, rst_n_i, sample_valid_i, sclk, cs_n;
  logic        dout_o, dout_oe_n_o, sample_ready_o, conv_start_o;
  adcsr_word_s sample_i;
  adcsr_mode_e power_mode_o;
  int          n_fail, n_tests, seed, n_pulse;
  time         t_rise;
  logic [11:0] code;
  logic [11:0] corner [4] = '{12'h000, 12'hFFF, 12'h800, 12'h001};
  int          hi_tab [3] = '{4, 14, 9};
  adcsr_mode_e md_tab [3] = '{ADCSR_PARTIAL, ADCSR_FULL, ADCSR_FULL};

  adcsr_readout u_adcsr_readout (.clock_i(clock_i), .rst_n_i(rst_n_i), .sample_i(sample_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .conv_start_o(conv_start_o),
    .power_mode_o(power_mode_o), .sclk_i(sclk), .convert_start_n_i(cs_n), .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o));
  adcsr_host u_adcsr_host (.sclk_o(sclk), .convert_start_n_o(cs_n), .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o));

  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) if (conv_start_o === 1'b1) n_pulse++;
  always @(posedge sclk) t_rise = $time;
  always @(dout_o) if (rst_n_i === 1'b1) check_bit("dout_on_rise", 1'b1, $time == t_rise);
  always @(negedge cs_n) begin
    #2;
    check_bit("oe_n_at_start", 1'b0, dout_oe_n_o);
    check_bit("dout_at_start", 1'b0, dout_o);
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_frame(input logic [11:0] c);
    return {3'b000, c, 1'b0};
  endfunction : exp_frame

  task automatic check_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit

  task automatic check_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val

  task automatic handoff(input logic [11:0] c);
    int k;
    k = 0;
    @(negedge clock_i);
    while (sample_ready_o !== 1'b1 && k < 200) begin
      @(negedge clock_i);
      k++;
    end
    check_bit("ready_free", 1'b1, sample_ready_o);
    sample_i.code  = c;
    sample_valid_i = 1'b1;
    @(negedge clock_i);
    sample_valid_i = 1'b0;
    check_bit("ready_busy", 1'b0, sample_ready_o);
  endtask : handoff

  task automatic data_frame(input logic pol, input logic pha, input logic [11:0] c);
    int p;
    handoff(c);
    p = n_pulse;
    u_adcsr_host.frame(pol, pha, 17);
    #40;
    check_val("frame", exp_frame(c), u_adcsr_host.rx[15:0]);
    check_bit("released", 1'b1, dout_oe_n_o);
    check_val("start_pulses", 16'h0001, 16'(n_pulse - p));
    check_val("mode_normal", 16'(ADCSR_NORMAL), 16'(power_mode_o));
  endtask : data_frame

  // Continuous pair: one word read out twice without a gap
  task automatic cont_pair(input logic pol, input logic pha, input logic [11:0] c);
    int p;
    handoff(c);
    p = n_pulse;
    u_adcsr_host.chain(pol, pha);
    #40;
    check_val("cont_first", exp_frame(c), u_adcsr_host.rx[31:16]);
    check_val("cont_second", exp_frame(c), u_adcsr_host.rx[15:0]);
    check_bit("cont_released", 1'b1, dout_oe_n_o);
    check_val("cont_pulses", 16'h0002, 16'(n_pulse - p));
  endtask : cont_pair

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    $display("MISMATCH watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    clock_i = 1'b0;
    rst_n_i = 1'b0;
    sample_valid_i = 1'b0;
    sample_i = '0;
    n_fail = 0;
    n_tests = 0;
    n_pulse = 0;
    seed = 39;
    t_rise = 0;
    repeat (4) @(posedge clock_i);
    // Link reset is synced on sclk, so it must run while reset is low
    repeat (3) u_adcsr_host.cyc(0, 1'b1, 1'b0);
    @(negedge clock_i) rst_n_i = 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 3; k++) begin
        code = (k == 0) ? corner[m] : 12'($random(seed));
        data_frame(m[1], m[0], code);
      end
      cont_pair(m[1], m[0], 12'($random(seed)));
    end
    for (int j = 0; j < 3; j++) begin
      u_adcsr_host.frame(1'b0, 1'b0, hi_tab[j]);
      repeat (10) @(negedge clock_i);
      check_bit("dropped", 1'b1, dout_oe_n_o);
      check_val("mode_down", 16'(md_tab[j]), 16'(power_mode_o));
    end
    data_frame(1'b1, 1'b0, 12'($random(seed)));
    stop_test();
  end
endmodule : adcsr_readout_tb
